/* logic/adc_link_regs.svh */
// constants shared by both ends of the converter serial link
`ifndef ADC_LINK_REGS_SVH
`define ADC_LINK_REGS_SVH

// ----------------------------------------------------------------
// controller register offsets (byte addresses on apb)
// ----------------------------------------------------------------
`define CTRL_OFS 8'h00
`define DIV_OFS 8'h04
`define STAT_OFS 8'h08
`define RES_OFS 8'h0c
`define RAW_OFS 8'h10

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CTRL_GO_BIT 0
`define CTRL_SGL_BIT 1
`define CTRL_CH_LSB 2
`define CTRL_CH_MSB 4
`define CTRL_CPOL_BIT 5
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define DIV_RESET 16'h000c
`define DIV_MIN 16'h0001

// ----------------------------------------------------------------
// framing: three bytes, first one seven zeros then the start bit
// ----------------------------------------------------------------
`define FRAME_BITS 5'd24
`define PAD_BYTE 8'h01

// ----------------------------------------------------------------
// clock index after the start bit (start clock is index 0)
// ----------------------------------------------------------------
`define IDX_CMD_LAST 5'd4
`define IDX_SAMPLE_ON 5'd4
`define IDX_SAMPLE_END 5'd5
`define IDX_MSB_FIRST 5'd6
`define IDX_MSB_LAST 5'd15
`define IDX_LSBF_LAST 5'd24
`define IDX_SAT 5'd25

// ----------------------------------------------------------------
// timing: result must be clocked out within the hold limit
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define HOLD_LIMIT_NS 1200000
`define HOLD_LIMIT_CYC (`HOLD_LIMIT_NS / `CLK_PERIOD_NS)
`define HOLD_HALF_PERIODS 22

`endif

/* logic/adc_link_pkg.sv */
// types shared by both ends of the converter serial link
package adc_link_pkg;

   // device command and conversion progress
   typedef enum logic [1:0] {
      DEV_WAIT_START,
      DEV_CMD,
      DEV_CONV
   } dev_state_t;

   // controller frame sequencing
   typedef enum logic [1:0] {
      HOST_IDLE,
      HOST_RUN,
      HOST_END
   } host_state_t;

   // decoded input selection
   typedef struct packed {
      logic diff;
      logic [2:0] pos;
      logic [2:0] neg;
   } chan_sel_t;

endpackage

/* logic/spi_link_if.sv */
// four-wire serial link between the controller and the converter
`timescale 1ns/100ps
interface spi_link_if;
   logic cs_n;
   logic sclk;
   logic mosi;
   logic miso_o;
   logic miso_oe;
   logic miso;

   // released line reads low, as if a weak pull-down held it
   assign miso = miso_oe & miso_o;

   modport dev (
      input cs_n,
      input sclk,
      input mosi,
      output miso_o,
      output miso_oe
   );

   modport host (
      output cs_n,
      output sclk,
      output mosi,
      input miso
   );
endinterface // spi_link_if

/* logic/adc_serial_device.sv */
// converter end of the serial link: command decode, sampling, result shift
// Contract
// - single-ended: channel field picks input 0..7
// - differential: pair 2k/2k+1, bit0 picks positive
// - four-input variant ignores channel field bit2
// - byte-only host pads clocks to multiple of eight
// - host drives on falling, captures on rising
// - first host byte: seven zeros, start bit
// - result msb driven on falling of clock fourteen
// - output released for first five second-byte clocks
// - second byte: five undefined, null, two msbs
// - third byte: eight low result bits, msb first
// - works with clock idling low or high
// - serial output changes only on falling edges
// - one result bit resolved per clock
// - host clocks ten bits within hold limit
// - any clock period or duty accepted
// - first high input clock is start; mode, channel
// - sample from fourth rise to fifth fall
// - null, msb-first, lsb-first repeat, then zeros
// - select high aborts conversion, enters standby
`timescale 1ns/100ps
`include "adc_link_regs.svh"

module adc_serial_device #(
   parameter bit EIGHT_INPUTS = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rst,
   spi_link_if.dev link,
   input wire logic [9:0] conv_code,
   output logic sel_diff,
   output logic [2:0] sel_pos,
   output logic [2:0] sel_neg,
   output logic sample_en,
   output logic standby,
   output logic [9:0] result,
   output logic result_valid
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   // decode mode bit and channel field into a selection
   function automatic adc_link_pkg::chan_sel_t chan_decode(
      input logic [3:0] cmd,
      input logic eight
   );
      adc_link_pkg::chan_sel_t s;
      logic hi;
      hi = eight & cmd[2];
      s.diff = ~cmd[3];
      if (cmd[3]) begin
         s.pos = {hi, cmd[1], cmd[0]};
         s.neg = 3'h0;
      end else begin
         s.pos = {hi, cmd[1], cmd[0]};
         s.neg = {hi, cmd[1], ~cmd[0]};
      end
      return s;
   endfunction

   // bit position of the result sent on a given clock index
   function automatic logic [3:0] bit_pos(input logic [4:0] idx);
      logic [4:0] p;
      if (idx <= `IDX_MSB_LAST) begin
         p = `IDX_MSB_LAST - idx;
      end else begin
         p = idx - `IDX_MSB_LAST;
      end
      return p[3:0];
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   adc_link_pkg::dev_state_t state_r;
   logic sclk_q_r;
   logic [4:0] idx_r;
   logic [3:0] cmd_r;
   logic [9:0] code_r;
   logic [9:0] res_r;
   logic miso_r;
   logic oe_r;
   logic sample_r;
   logic [9:0] result_r;
   logic valid_r;
   adc_link_pkg::chan_sel_t sel_r;

   // ----------------------------------------------------------------
   // edge and phase decode
   // ----------------------------------------------------------------

   // edges seen by comparing with last cycle; no clock idle level is
   // assumed, so both idle-low and idle-high hosts work
   wire logic sel_active = ~link.cs_n;
   wire logic sclk_rise = link.sclk & ~sclk_q_r;
   wire logic sclk_fall = ~link.sclk & sclk_q_r;
   wire logic started = (state_r != adc_link_pkg::DEV_WAIT_START);
   wire logic start_seen = sclk_rise & link.mosi &
                           (state_r == adc_link_pkg::DEV_WAIT_START);
   wire logic [4:0] idx_inc = (idx_r == `IDX_SAT) ? idx_r : idx_r + 5'd1;
   wire logic cmd_clock = started & (idx_inc <= `IDX_CMD_LAST);
   wire logic at_sample_end = (idx_r == `IDX_SAMPLE_END);
   wire logic msb_phase = (idx_r >= `IDX_MSB_FIRST) & (idx_r <= `IDX_MSB_LAST);
   wire logic lsbf_phase = (idx_r > `IDX_MSB_LAST) & (idx_r <= `IDX_LSBF_LAST);
   wire logic [3:0] out_pos = bit_pos(idx_r);
   wire logic out_bit = code_r[out_pos];

   // ----------------------------------------------------------------
   // previous serial clock level
   // ----------------------------------------------------------------

   // tracked even while deselected so the first edge after select is real
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sclk_q_r <= 1'b0;
      end else begin
         sclk_q_r <= link.sclk;
      end
   end

   // ----------------------------------------------------------------
   // command capture on rising edges
   // ----------------------------------------------------------------

   // host changes data on falling edges, so rising edges see it stable
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r <= adc_link_pkg::DEV_WAIT_START;
         idx_r <= 5'h00;
         cmd_r <= 4'h0;
      end else if (!sel_active) begin
         state_r <= adc_link_pkg::DEV_WAIT_START;
         idx_r <= 5'h00;
      end else if (start_seen) begin
         state_r <= adc_link_pkg::DEV_CMD;
         idx_r <= 5'h00;
      end else if (started & sclk_rise) begin
         idx_r <= idx_inc;
         if (cmd_clock) begin
            cmd_r <= {cmd_r[2:0], link.mosi};
         end
      end else if (started & sclk_fall & at_sample_end) begin
         state_r <= adc_link_pkg::DEV_CONV;
      end
   end

   // ----------------------------------------------------------------
   // sampling window and selection outputs
   // ----------------------------------------------------------------

   // selection is frozen while sampling, held for the conversion
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sample_r <= 1'b0;
         sel_r <= '0;
      end else if (!sel_active) begin
         sample_r <= 1'b0;
      end else if (started & sclk_rise & (idx_inc == `IDX_SAMPLE_ON)) begin
         sample_r <= 1'b1;
         sel_r <= chan_decode({cmd_r[2:0], link.mosi}, EIGHT_INPUTS);
      end else if (started & sclk_fall & at_sample_end) begin
         sample_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // result shift on falling edges
   // ----------------------------------------------------------------

   // the code is frozen at the end of sampling; one bit is resolved
   // per clock, so a stalled clock simply pauses the conversion
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         code_r <= 10'h000;
         res_r <= 10'h000;
         miso_r <= 1'b0;
         oe_r <= 1'b0;
      end else if (!sel_active) begin
         oe_r <= 1'b0;
         miso_r <= 1'b0;
      end else if (started & sclk_fall) begin
         if (at_sample_end) begin
            code_r <= conv_code;
            res_r <= 10'h000;
            oe_r <= 1'b1;
            miso_r <= 1'b0;
         end else if (msb_phase) begin
            miso_r <= out_bit;
            res_r[out_pos] <= out_bit;
         end else if (lsbf_phase) begin
            miso_r <= out_bit;
         end else if (state_r == adc_link_pkg::DEV_CONV) begin
            miso_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // completed result for the user side
   // ----------------------------------------------------------------

   // valid only when the last msb-first bit went out before deselect
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         result_r <= 10'h000;
         valid_r <= 1'b0;
      end else begin
         valid_r <= 1'b0;
         if (sel_active & started & sclk_fall & (idx_r == `IDX_MSB_LAST)) begin
            result_r <= {res_r[9:1], out_bit};
            valid_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign link.miso_o = miso_r;
   assign link.miso_oe = oe_r & sel_active;
   assign sample_en = sample_r;
   assign standby = ~sel_active;
   assign sel_diff = sel_r.diff;
   assign sel_pos = sel_r.pos;
   assign sel_neg = sel_r.neg;
   assign result = result_r;
   assign result_valid = valid_r;

endmodule // adc_serial_device

/* logic/adc_serial_host.sv */
// controller end of the serial link with an apb register port
`timescale 1ns/100ps
`include "adc_link_regs.svh"

module adc_serial_host #(
   parameter int HOLD_LIMIT_CYC = `HOLD_LIMIT_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   spi_link_if.host link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   localparam logic [15:0] DIV_MAX = 16'(HOLD_LIMIT_CYC / `HOLD_HALF_PERIODS);

   // keep the half period inside what the hold limit allows
   function automatic logic [15:0] div_clamp(input logic [15:0] v);
      if (v < `DIV_MIN) begin
         return `DIV_MIN;
      end else if (v > DIV_MAX) begin
         return DIV_MAX;
      end
      return v;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   adc_link_pkg::host_state_t state_r;
   logic sgl_r;
   logic [2:0] ch_r;
   logic cpol_r;
   logic [15:0] div_r;
   logic done_r;
   logic [9:0] result_r;
   logic [23:0] raw_r;
   logic [15:0] tcnt_r;
   logic [23:0] tx_r;
   logic [23:0] rx_r;
   logic [4:0] rises_r;
   logic cs_n_r;
   logic sclk_r;
   logic mosi_r;
   logic [31:0] prdata_r;
   logic pslverr_r;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   wire logic setup = psel & ~penable;
   wire logic wr_acc = psel & penable & pwrite;
   wire logic hit_ctrl = (paddr == `CTRL_OFS);
   wire logic hit_div = (paddr == `DIV_OFS);
   wire logic hit_stat = (paddr == `STAT_OFS);
   wire logic hit_res = (paddr == `RES_OFS);
   wire logic hit_raw = (paddr == `RAW_OFS);
   wire logic mapped = hit_ctrl | hit_div | hit_stat | hit_res | hit_raw;
   wire logic busy = (state_r != adc_link_pkg::HOST_IDLE);
   wire logic go = wr_acc & hit_ctrl & pwdata[`CTRL_GO_BIT] & ~busy;
   wire logic done_clr = wr_acc & hit_stat & pwdata[`STAT_DONE_BIT];
   wire logic tick = busy & (tcnt_r == div_r - 16'h0001);
   wire logic frame_end = tick & (state_r == adc_link_pkg::HOST_END);
   wire logic [31:0] rd_mux =
      hit_ctrl ? {26'h0, cpol_r, ch_r, sgl_r, 1'b0} :
      hit_div ? {16'h0, div_r} :
      hit_stat ? {30'h0, done_r, busy} :
      hit_res ? {22'h0, result_r} :
      hit_raw ? {8'h00, raw_r} : 32'h0;

   // ----------------------------------------------------------------
   // apb slave: read data latched in setup, zero wait states
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prdata_r <= 32'h0;
         pslverr_r <= 1'b0;
      end else if (setup) begin
         prdata_r <= pwrite ? 32'h0 : rd_mux;
         pslverr_r <= ~mapped;
      end
   end

   // ----------------------------------------------------------------
   // configuration and status registers
   // ----------------------------------------------------------------

   // settings are locked while a frame runs so the command stays whole
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sgl_r <= 1'b1;
         ch_r <= 3'h0;
         cpol_r <= 1'b0;
         div_r <= `DIV_RESET;
         done_r <= 1'b0;
         result_r <= 10'h000;
         raw_r <= 24'h0;
      end else begin
         if (wr_acc & hit_ctrl & ~busy) begin
            sgl_r <= pwdata[`CTRL_SGL_BIT];
            ch_r <= pwdata[`CTRL_CH_MSB:`CTRL_CH_LSB];
            cpol_r <= pwdata[`CTRL_CPOL_BIT];
         end
         if (wr_acc & hit_div & ~busy) begin
            div_r <= div_clamp(pwdata[15:0]);
         end
         // a frame ending in the clearing cycle still leaves done set
         if (frame_end) begin
            done_r <= 1'b1;
            result_r <= rx_r[9:0];
            raw_r <= rx_r;
         end else if (done_clr) begin
            done_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // frame engine: one half clock period per tick
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r <= adc_link_pkg::HOST_IDLE;
         tcnt_r <= 16'h0;
         tx_r <= 24'h0;
         rx_r <= 24'h0;
         rises_r <= 5'h00;
         cs_n_r <= 1'b1;
         sclk_r <= 1'b0;
         mosi_r <= 1'b0;
      end else begin
         tcnt_r <= (tick | ~busy) ? 16'h0 : tcnt_r + 16'h0001;
         case (state_r)
            adc_link_pkg::HOST_IDLE: begin
               sclk_r <= cpol_r;
               cs_n_r <= 1'b1;
               if (go) begin
                  tx_r <= {`PAD_BYTE, sgl_r, ch_r, 12'h000};
                  mosi_r <= 1'b0;
                  rises_r <= 5'h00;
                  cs_n_r <= 1'b0;
                  state_r <= adc_link_pkg::HOST_RUN;
               end
            end
            adc_link_pkg::HOST_RUN: begin
               if (tick) begin
                  sclk_r <= ~sclk_r;
                  if (!sclk_r) begin
                     rx_r <= {rx_r[22:0], link.miso};
                     rises_r <= rises_r + 5'd1;
                     if (rises_r + 5'd1 == `FRAME_BITS) begin
                        state_r <= adc_link_pkg::HOST_END;
                     end
                  end else if (rises_r != 5'h00) begin
                     tx_r <= {tx_r[22:0], 1'b0};
                     mosi_r <= tx_r[22];
                  end
               end
            end
            adc_link_pkg::HOST_END: begin
               if (tick) begin
                  sclk_r <= cpol_r;
                  cs_n_r <= 1'b1;
                  state_r <= adc_link_pkg::HOST_IDLE;
               end
            end
            default: begin
               state_r <= adc_link_pkg::HOST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign link.cs_n = cs_n_r;
   assign link.sclk = sclk_r;
   assign link.mosi = mosi_r;
   assign prdata = prdata_r;
   assign pready = 1'b1;
   assign pslverr = pslverr_r & psel & penable;

endmodule // adc_serial_host

/* verif/adc_link_checker.sv */
// concurrent checks on the serial link between controller and converter
`timescale 1ns/100ps
module adc_link_checker (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic miso_o,
   input wire logic miso_oe,
   input wire logic miso
);
   // ----------------------------------------------------------------
   // edge counts inside one frame
   // ----------------------------------------------------------------
   logic [5:0] rise_cnt_r;
   logic [5:0] fall_cnt_r;

   // cleared while deselected so every frame counts from zero
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rise_cnt_r <= 6'h00;
         fall_cnt_r <= 6'h00;
      end else if (cs_n) begin
         rise_cnt_r <= 6'h00;
         fall_cnt_r <= 6'h00;
      end else begin
         rise_cnt_r <= rise_cnt_r + 6'($rose(sclk));
         // a fall before the first rise only leaves the idle-high level
         fall_cnt_r <= fall_cnt_r + 6'($fell(sclk) && rise_cnt_r != 6'h00);
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   a_out_released: assert property (cs_n && $past(cs_n) |-> !miso_oe)
      else $error("data out driven while deselected");
   // assumes a half period of at least two cycles, as the bench sets
   a_miso_on_fall: assert property (miso_oe && $past(miso_oe) && $changed(miso_o)
      |-> !sclk && !$past(sclk))
      else $error("data out changed away from a falling clock");
   a_mosi_on_fall: assert property (!cs_n && $past(!cs_n) && $changed(mosi)
      |-> $fell(sclk))
      else $error("command line changed away from a falling clock");
   a_frame_rises: assert property ($rose(cs_n) |-> rise_cnt_r == 6'd24)
      else $error("frame clock count is not three bytes");
   a_hiz_count: assert property ($rose(miso_oe) |-> fall_cnt_r == 6'd13)
      else $error("data out driven at the wrong clock");
   a_null_low: assert property ($rose(miso_oe) |-> !miso_o && !miso)
      else $error("null bit not low");
   a_cs_gap: assert property ($rose(cs_n) |=> cs_n)
      else $error("select not raised between frames");
   a_select_steady: assert property ($fell(cs_n) |-> $stable(sclk) ##1 $stable(sclk))
      else $error("clock left its idle level at select");
endmodule // adc_link_checker

/* verif/tb_top.sv */
// self-checking bench joining the controller and two converter ends
`timescale 1ns/100ps
`include "adc_link_regs.svh"
module tb_top;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [9:0] conv_code = 10'h000;
   logic [9:0] result;
   logic [9:0] result_f;
   logic [2:0] pos, neg, pos_f, neg_f;
   logic diff, diff_f, standby, samp, valid;
   int n_valid;
   int n_samp;
   logic [31:0] rd;
   logic err;
   int n_errors = 0;
   int cmp_count = 0;

   // ----------------------------------------------------------------
   // ends of the link; the four-input end only listens
   // ----------------------------------------------------------------
   spi_link_if link();
   spi_link_if link_f();
   assign link_f.cs_n = link.cs_n;
   assign link_f.sclk = link.sclk;
   assign link_f.mosi = link.mosi;

   initial begin
      forever #20 ref_clk = ~ref_clk;
   end

   adc_serial_host #(.HOLD_LIMIT_CYC(220)) u_adc_serial_host (.ref_clk(ref_clk), .rst(rst),
      .link(link.host), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   adc_serial_device u_adc_serial_device (.ref_clk(ref_clk), .rst(rst), .link(link.dev),
      .conv_code(conv_code), .sel_diff(diff), .sel_pos(pos), .sel_neg(neg), .sample_en(samp),
      .standby(standby), .result(result), .result_valid(valid));
   adc_serial_device #(.EIGHT_INPUTS(1'b0)) u_adc_serial_device_four (.ref_clk(ref_clk),
      .rst(rst), .link(link_f.dev), .conv_code(conv_code), .sel_diff(diff_f),
      .sel_pos(pos_f), .sel_neg(neg_f), .sample_en(), .standby(), .result(result_f),
      .result_valid());
   adc_link_checker u_adc_link_checker (.ref_clk(ref_clk), .rst(rst), .cs_n(link.cs_n),
      .sclk(link.sclk), .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe(link.miso_oe),
      .miso(link.miso));

   // pulse and window counts of the eight-input end, compared per frame
   always_ff @(posedge ref_clk) begin
      n_valid <= n_valid + int'(valid === 1'b1);
      n_samp <= n_samp + int'(samp === 1'b1);
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // one apb transfer; read data and error taken at the completing edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) begin
         n_errors++;
         conclude();
      end
   endtask

   task automatic wait_done();
      int k;
      for (k = 0; k < 2000; k++) begin
         apb(1'b0, `STAT_OFS, 32'h0);
         if (rd[`STAT_DONE_BIT] === 1'b1) break;
      end
      if (k >= 2000) begin
         n_errors++;
         conclude();
      end
   endtask

   // one conversion frame; bit 1 of the index picks the clock idle level
   task automatic frame(input int i);
      logic [2:0] ch;
      logic sgl;
      logic [9:0] code;
      logic [31:0] ctl;
      int v0;
      int s0;
      ch = i[2:0];
      sgl = i[3];
      code = 10'h2c7 + 10'(i * 73);
      ctl = {26'h0, i[1], ch, sgl, 1'b1};
      conv_code <= code;
      v0 = n_valid;
      s0 = n_samp;
      // idle level settles before select, so the frame runs in the wanted mode
      apb(1'b1, `CTRL_OFS, ctl & 32'h3e);
      apb(1'b1, `CTRL_OFS, ctl);
      apb(1'b1, `CTRL_OFS, 32'h0);
      wait_done();
      check("clock idle", {31'h0, link.sclk}, {31'h0, i[1]});
      check("valid pulses", n_valid - v0, 32'h1);
      check("sample window", n_samp - s0, 32'hc);
      apb(1'b0, `RES_OFS, 32'h0);
      check("result", rd, {22'h0, code});
      apb(1'b0, `RAW_OFS, 32'h0);
      check("raw frame", rd, {22'h0, code});
      apb(1'b0, `CTRL_OFS, 32'h0);
      check("ctrl kept while busy", rd, ctl & 32'h3e);
      check("sel eight", {25'h0, diff, pos, neg},
         {25'h0, !sgl, ch, sgl ? 3'h0 : ch ^ 3'h1});
      check("sel four", {25'h0, diff_f, pos_f, neg_f},
         {25'h0, !sgl, 1'b0, ch[1:0], sgl ? 3'h0 : {1'b0, ch[1], !ch[0]}});
      check("result four", {22'h0, result_f}, {22'h0, code});
      check("result eight", {22'h0, result}, {22'h0, code});
      check("standby", {31'h0, standby}, 32'h1);
      apb(1'b1, `STAT_OFS, 32'h2);
      apb(1'b0, `STAT_OFS, 32'h0);
      check("done cleared", rd, 32'h0);
   endtask

   // ----------------------------------------------------------------
   // main sequence and hang guard
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      apb(1'b0, `CTRL_OFS, 32'h0);
      check("ctrl reset", rd, 32'h2);
      apb(1'b0, `DIV_OFS, 32'h0);
      check("div reset", rd, {16'h0, `DIV_RESET});
      apb(1'b0, 8'h14, 32'h0);
      check("unmapped data", rd, 32'h0);
      check("unmapped error", {31'h0, err}, 32'h1);
      apb(1'b1, `DIV_OFS, 32'h0);
      apb(1'b0, `DIV_OFS, 32'h0);
      check("div low clamp", rd, 32'h1);
      apb(1'b1, `DIV_OFS, 32'hff);
      apb(1'b0, `DIV_OFS, 32'h0);
      check("div high clamp", rd, 32'ha);
      apb(1'b1, `DIV_OFS, 32'h4);
      $display("test registers done");
      for (int i = 0; i < 16; i++) begin
         frame(i);
      end
      $display("test channel sweep done");
      // reset lands in mid-frame, then a fresh frame must still work
      apb(1'b1, `CTRL_OFS, 32'h3);
      repeat (100) @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      check("select after abort", {31'h0, link.cs_n}, 32'h1);
      check("out after abort", {31'h0, link.miso_oe}, 32'h0);
      rst <= 1'b0;
      apb(1'b1, `DIV_OFS, 32'h4);
      frame(21);
      $display("test abort restart done");
      conclude();
   end

   initial begin
      repeat (100000) @(posedge ref_clk);
      n_errors++;
      conclude();
   end
endmodule // tb_top
